// file: wes_consts.svh
// Constants for the wake event and ready logic and its controller
`ifndef WES_CONSTS_SVH
`define WES_CONSTS_SVH

// ----------------------------------------------------------------------
// Device register offsets on the link
// ----------------------------------------------------------------------
`define WES_OFF_PWC 8'h84
`define WES_OFF_HWCFG 8'h74
`define WES_OFF_BYTE_TEST 8'h64
`define WES_BYTE_TEST_VAL 32'h1234abcd

// ----------------------------------------------------------------------
// Field positions of power_wake_control
// ----------------------------------------------------------------------
`define WES_BIT_READY 0
`define WES_BIT_OUT_EN 1
`define WES_BIT_POL 2
`define WES_BIT_PULSE_SEL 3
`define WES_CAUSE_LO 4
`define WES_CAUSE_HI 5
`define WES_BIT_DRIVE 6
`define WES_BIT_ENERGY_DETECT_ENABLE 8
`define WES_BIT_FRAME_EN 9
`define WES_PSS_LO 12
`define WES_PSS_HI 13

// ----------------------------------------------------------------------
// Power state select encodings
// ----------------------------------------------------------------------
`define WES_PSS_NORMAL 2'h0
`define WES_PSS_FRAME 2'h1
`define WES_PSS_ENERGY 2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define WES_CLK_HZ 20000000
`define WES_PULSE_MS 50
`define WES_PULSE_CYCLES ((`WES_PULSE_MS * `WES_CLK_HZ) / 1000)
`define WES_STAB_CYCLES 64

// ----------------------------------------------------------------------
// Controller register offsets on AHB-Lite
// ----------------------------------------------------------------------
`define WES_HOFF_CMD 8'h00
`define WES_HOFF_WDATA 8'h04
`define WES_HOFF_RDATA 8'h08
`define WES_HOFF_STATUS 8'h0c
`define WES_CMD_WRITE_BIT 0
`define WES_CMD_ADDR_LO 8
`define WES_CMD_ADDR_HI 15
`define WES_ST_BUSY 0
`define WES_ST_READY_SEEN 1
`define WES_ST_REFUSED 2

`endif

// file: wes_pkg.sv
// Types shared by the wake event device end and its controller
`default_nettype none
package wes_pkg;
   typedef enum logic [1:0] {WES_RUN, WES_SLEEP, WES_WAKING} wes_pstate_t;
   typedef enum logic {WES_H_IDLE, WES_H_REQ} wes_hstate_t;
endpackage
`default_nettype wire

// file: wes_link_if.sv
// Register link between the controller and the wake event device
`timescale 1ns/10ps
`default_nettype none
interface wes_link_if;
   logic req;
   logic we;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic ack;
   logic [31:0] rdata;
   modport device (input req, input we, input addr, input wdata, output ack, output rdata);
   modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface
`default_nettype wire

// file: wes_device.sv
// Wake event status, wake output and ready logic of the device end
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`include "wes_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module wes_device
   import wes_pkg::*;
#(
   parameter int unsigned PULSE_CYCLES = `WES_PULSE_CYCLES,
   parameter int unsigned STAB_CYCLES = `WES_STAB_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   wes_link_if.device link,
   input wire logic energy_src,
   input wire logic frame_src,
   output logic wake_event_output,
   output logic wake_event_output_oe_n,
   output logic wake_event_interrupt,
   output logic device_ready
);
   localparam int PW = $clog2(PULSE_CYCLES + 1);
   localparam int SW = $clog2(STAB_CYCLES + 1);

   wes_pstate_t pstate_q;
   logic [SW-1:0] stab_cnt_q;
   logic [PW-1:0] pulse_cnt_q;
   logic [1:0] power_state_select_q;
   logic wake_frame_enable_q;
   logic energy_detect_enable_q;
   logic wake_output_drive_type_q;
   logic [1:0] wake_cause_field_q;
   logic wake_pulse_select_q;
   logic wake_output_polarity_q;
   logic wake_output_enable_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic out_q;
   logic oe_n_q;

   logic ready;
   logic take;
   logic wr_pwc;
   logic wr_byte_test;
   logic [1:0] enables;
   logic [1:0] pending;
   logic [1:0] set_v;
   logic [1:0] clr_v;
   logic new_event;
   logic trig;
   logic active;
   logic asserted;
   logic wake_req;
   logic [31:0] pwc_value;

   // ----------------------------------------------------------------------
   // Link decode
   // ----------------------------------------------------------------------
   assign ready = (pstate_q == WES_RUN);
   // One take per request: the held request is not seen again while acked
   assign take = ce && link.req && !ack_q;
   assign wr_pwc = take && link.we && (link.addr == `WES_OFF_PWC) && ready;
   assign wr_byte_test = take && link.we && (link.addr == `WES_OFF_BYTE_TEST);

   // ----------------------------------------------------------------------
   // Wake cause tracking
   // ----------------------------------------------------------------------
   assign enables = {wake_frame_enable_q, energy_detect_enable_q};
   assign pending = {frame_src, energy_src};
   assign set_v = pending & enables;
   // Clear only in full power, and never over a pending source
   assign clr_v = wr_pwc ? (link.wdata[`WES_CAUSE_HI:`WES_CAUSE_LO] & ~pending) : 2'h0;
   assign new_event = |(set_v & ~wake_cause_field_q);
   assign trig = |(wake_cause_field_q & enables);
   assign wake_event_interrupt = trig;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wake_cause_field_q <= 2'h0;
      end else if (ce) begin
         // Set wins over a clear in the same cycle
         wake_cause_field_q <= set_v | (wake_cause_field_q & ~clr_v);
      end
   end

   // ----------------------------------------------------------------------
   // Pulse timer
   // ----------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pulse_cnt_q <= '0;
      end else if (ce) begin
         if (!wake_pulse_select_q) begin
            pulse_cnt_q <= '0;
         end else if (pulse_cnt_q != '0) begin
            // Cut short once the cause or its enable is gone
            pulse_cnt_q <= trig ? pulse_cnt_q - PW'(1) : '0;
         end else if (new_event) begin
            // Starts on the edge that sets the cause, before trig is seen
            pulse_cnt_q <= PW'(PULSE_CYCLES);
         end
      end
   end

   assign active = wake_pulse_select_q ? (pulse_cnt_q != '0) : trig;
   assign asserted = active && wake_output_enable_q;

   // ----------------------------------------------------------------------
   // Wake pin driver
   // ----------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else if (ce) begin
         if (wake_output_drive_type_q) begin
            out_q <= wake_output_polarity_q ? asserted : !asserted;
            oe_n_q <= 1'b0;
         end else begin
            // Wired-or line: only ever pull low, polarity ignored
            out_q <= 1'b0;
            oe_n_q <= !asserted;
         end
      end
   end

   assign wake_event_output = out_q;
   assign wake_event_output_oe_n = oe_n_q;

   // ----------------------------------------------------------------------
   // Power state and ready
   // ----------------------------------------------------------------------
   assign wake_req = ((power_state_select_q == `WES_PSS_FRAME) && wake_cause_field_q[1]) ||
                     ((power_state_select_q == `WES_PSS_ENERGY) && wake_cause_field_q[0]);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pstate_q <= WES_WAKING;
         stab_cnt_q <= SW'(STAB_CYCLES);
      end else if (ce) begin
         case (pstate_q)
            WES_RUN: begin
               if (wr_pwc && link.wdata[`WES_PSS_HI:`WES_PSS_LO] != `WES_PSS_NORMAL) begin
                  pstate_q <= WES_SLEEP;
               end
            end
            WES_SLEEP: begin
               if (wr_byte_test || wake_req) begin
                  pstate_q <= WES_WAKING;
                  stab_cnt_q <= SW'(STAB_CYCLES);
               end
            end
            WES_WAKING: begin
               // Ready rises only after the settle count runs out
               if (stab_cnt_q == '0) begin
                  pstate_q <= WES_RUN;
               end else begin
                  stab_cnt_q <= stab_cnt_q - SW'(1);
               end
            end
            default: begin
               pstate_q <= WES_WAKING;
               stab_cnt_q <= SW'(STAB_CYCLES);
            end
         endcase
      end
   end

   assign device_ready = ready;

   // ----------------------------------------------------------------------
   // Control bits
   // ----------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         power_state_select_q <= `WES_PSS_NORMAL;
         wake_frame_enable_q <= 1'b0;
         energy_detect_enable_q <= 1'b0;
         wake_output_drive_type_q <= 1'b0;
         wake_pulse_select_q <= 1'b0;
         wake_output_polarity_q <= 1'b0;
         wake_output_enable_q <= 1'b0;
      end else if (ce) begin
         if (wr_pwc) begin
            power_state_select_q <= link.wdata[`WES_PSS_HI:`WES_PSS_LO];
            wake_frame_enable_q <= link.wdata[`WES_BIT_FRAME_EN];
            energy_detect_enable_q <= link.wdata[`WES_BIT_ENERGY_DETECT_ENABLE];
            wake_output_drive_type_q <= link.wdata[`WES_BIT_DRIVE];
            wake_pulse_select_q <= link.wdata[`WES_BIT_PULSE_SEL];
            wake_output_polarity_q <= link.wdata[`WES_BIT_POL];
            wake_output_enable_q <= link.wdata[`WES_BIT_OUT_EN];
         end else if (pstate_q == WES_WAKING && stab_cnt_q == '0) begin
            // Self-clearing once back in full power
            power_state_select_q <= `WES_PSS_NORMAL;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   always_comb begin
      pwc_value = 32'h0;
      pwc_value[`WES_PSS_HI:`WES_PSS_LO] = power_state_select_q;
      pwc_value[`WES_BIT_FRAME_EN] = wake_frame_enable_q;
      pwc_value[`WES_BIT_ENERGY_DETECT_ENABLE] = energy_detect_enable_q;
      pwc_value[`WES_BIT_DRIVE] = wake_output_drive_type_q;
      pwc_value[`WES_CAUSE_HI:`WES_CAUSE_LO] = wake_cause_field_q;
      pwc_value[`WES_BIT_PULSE_SEL] = wake_pulse_select_q;
      pwc_value[`WES_BIT_POL] = wake_output_polarity_q;
      pwc_value[`WES_BIT_OUT_EN] = wake_output_enable_q;
      pwc_value[`WES_BIT_READY] = ready;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0;
      end else if (ce) begin
         ack_q <= take;
         if (take && !link.we) begin
            if (link.addr == `WES_OFF_PWC) begin
               rdata_q <= pwc_value;
            end else if (link.addr == `WES_OFF_BYTE_TEST && ready) begin
               rdata_q <= `WES_BYTE_TEST_VAL;
            end else begin
               rdata_q <= 32'h0;
            end
         end
      end
   end

   assign link.ack = ack_q;
   assign link.rdata = rdata_q;
endmodule
`default_nettype wire

// file: wes_host.sv
// Controller end: AHB-Lite registers drive orders over the device link
`include "wes_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module wes_host
   import wes_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   wes_link_if.host link
);
   wes_hstate_t hstate_q;
   logic wr_pend_q;
   logic [7:0] waddr_q;
   logic [31:0] hrdata_q;
   logic [31:0] wdata_q;
   logic [31:0] rdata_q;
   logic ready_seen_q;
   logic refused_q;
   logic req_we_q;
   logic [7:0] req_addr_q;

   logic a_take;
   logic cmd_wr;
   logic cmd_we;
   logic [7:0] cmd_addr;
   logic launch;
   logic refuse;
   logic done;
   logic [31:0] status;

   // Order allowed before ready is seen: two reads and the wake write
   function automatic logic wes_allowed(input logic seen, input logic we, input logic [7:0] a);
      wes_allowed = seen || (!we && (a == `WES_OFF_PWC || a == `WES_OFF_HWCFG)) ||
                    (we && a == `WES_OFF_BYTE_TEST);
   endfunction

   // ----------------------------------------------------------------------
   // AHB-Lite slave, zero wait states
   // ----------------------------------------------------------------------
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign a_take = ce && hsel && htrans[1] && hready && (hsize == 3'h2 || !hwrite || 1'b1);
   assign status = {29'h0, refused_q, ready_seen_q, (hstate_q != WES_H_IDLE)};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         waddr_q <= 8'h0;
         hrdata_q <= 32'h0;
      end else if (ce) begin
         wr_pend_q <= a_take && hwrite;
         waddr_q <= haddr[7:0];
         if (a_take && !hwrite) begin
            case (haddr[7:0])
               `WES_HOFF_WDATA: hrdata_q <= wdata_q;
               `WES_HOFF_RDATA: hrdata_q <= rdata_q;
               `WES_HOFF_STATUS: hrdata_q <= status;
               default: hrdata_q <= 32'h0;
            endcase
         end
      end
   end

   assign hrdata = hrdata_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wdata_q <= 32'h0;
      end else if (ce && wr_pend_q && waddr_q == `WES_HOFF_WDATA) begin
         wdata_q <= hwdata;
      end
   end

   // ----------------------------------------------------------------------
   // Order launch and gating
   // ----------------------------------------------------------------------
   assign cmd_wr = ce && wr_pend_q && (waddr_q == `WES_HOFF_CMD);
   assign cmd_we = hwdata[`WES_CMD_WRITE_BIT];
   assign cmd_addr = hwdata[`WES_CMD_ADDR_HI:`WES_CMD_ADDR_LO];
   // Orders written while busy are dropped
   assign launch = cmd_wr && (hstate_q == WES_H_IDLE) &&
                   wes_allowed(ready_seen_q, cmd_we, cmd_addr);
   assign refuse = cmd_wr && (hstate_q == WES_H_IDLE) &&
                   !wes_allowed(ready_seen_q, cmd_we, cmd_addr);
   assign done = ce && (hstate_q == WES_H_REQ) && link.ack;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hstate_q <= WES_H_IDLE;
         req_we_q <= 1'b0;
         req_addr_q <= 8'h0;
      end else if (ce) begin
         case (hstate_q)
            WES_H_IDLE: begin
               if (launch) begin
                  hstate_q <= WES_H_REQ;
                  req_we_q <= cmd_we;
                  req_addr_q <= cmd_addr;
               end
            end
            WES_H_REQ: begin
               if (link.ack) begin
                  hstate_q <= WES_H_IDLE;
               end
            end
            default: hstate_q <= WES_H_IDLE;
         endcase
      end
   end

   assign link.req = (hstate_q == WES_H_REQ);
   assign link.we = req_we_q;
   assign link.addr = req_addr_q;
   assign link.wdata = wdata_q;

   // ----------------------------------------------------------------------
   // Ready tracking, read data, refusal flag
   // ----------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ready_seen_q <= 1'b0;
         rdata_q <= 32'h0;
      end else if (ce) begin
         if (done && !req_we_q) begin
            rdata_q <= link.rdata;
            if (req_addr_q == `WES_OFF_PWC) begin
               ready_seen_q <= link.rdata[`WES_BIT_READY];
            end
         end
         if (launch && cmd_we && (cmd_addr == `WES_OFF_BYTE_TEST ||
             (cmd_addr == `WES_OFF_PWC &&
              wdata_q[`WES_PSS_HI:`WES_PSS_LO] != `WES_PSS_NORMAL))) begin
            // Device goes to or leaves a reduced state: poll again
            ready_seen_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         refused_q <= 1'b0;
      end else if (ce) begin
         if (refuse) begin
            refused_q <= 1'b1;
         end else if (wr_pend_q && waddr_q == `WES_HOFF_STATUS && hwdata[`WES_ST_REFUSED]) begin
            refused_q <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// file: wes_props.sv
// Concurrent checks on the wake event link and wake pin
`include "wes_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module wes_props #(
   parameter int unsigned PULSE_CYCLES = `WES_PULSE_CYCLES,
   parameter int unsigned STAB_CYCLES = `WES_STAB_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic req,
   input wire logic we,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic ack,
   input wire logic [31:0] rdata,
   input wire logic wake_event_output,
   input wire logic wake_event_output_oe_n,
   input wire logic wake_event_interrupt,
   input wire logic device_ready
);
   logic take;
   logic cw;
   logic pin_act;
   logic [31:0] cfg_q;
   logic [31:0] act_q;
   logic [31:0] up_q;
   // Mirror of accepted control writes; a write while not ready is dropped
   assign take = ce && req && !ack;
   assign cw = take && we && addr == `WES_OFF_PWC && device_ready;
   assign pin_act = cfg_q[6] ? wake_event_output == cfg_q[2] : !wake_event_output_oe_n;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) cfg_q <= '0;
      else if (cw) cfg_q <= wdata;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) act_q <= '0;
      else act_q <= (cfg_q[3] && pin_act) ? act_q + 1 : '0;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) up_q <= '0;
      else if (up_q < 1000) up_q <= up_q + 1;
   end
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_ACK_NEXT: assert property (take |=> ack)
      else $error("link request not answered next cycle");
   AST_ACK_PULSE: assert property (ack |=> !ack)
      else $error("link ack longer than one cycle");
   AST_READY_BIT: assert property (take && !we && addr == `WES_OFF_PWC |=>
      rdata[0] == $past(device_ready))
      else $error("ready bit read differs from ready");
   AST_READY_STAB: assert property (up_q < STAB_CYCLES |-> !device_ready)
      else $error("ready before stabilisation");
   AST_OD_LOW: assert property ((!cfg_q[6] && !cw) [*2] |-> !wake_event_output)
      else $error("open drain pin driven high");
   AST_OE_GATE: assert property ((!cfg_q[1] && !cw) [*2] |-> !pin_act)
      else $error("wake pin active while disabled");
   AST_STATIC: assert property ((cfg_q[1] && !cfg_q[3] && !cw) [*2] |->
      pin_act == $past(wake_event_interrupt))
      else $error("static wake pin disagrees with event");
   AST_PULSE_MAX: assert property (act_q <= PULSE_CYCLES)
      else $error("wake pulse too long");
   AST_INT_EN: assert property (wake_event_interrupt |-> cfg_q[8] || cfg_q[9])
      else $error("interrupt without event enable");
   COV_PULSE: cover property (cfg_q[3] && pin_act);
   COV_STATIC: cover property (!cfg_q[3] && pin_act);
   COV_READY: cover property ($rose(device_ready));
endmodule
`default_nettype wire

// file: wake_event_status_output_bench.sv
// Bench joining the controller and the wake event device
`include "wes_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module wake_event_status_output_bench;
   localparam int unsigned PC = 20;
   localparam int unsigned SC = 40;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic energy_src;
   logic frame_src;
   logic wake_event_output;
   logic wake_event_output_oe_n;
   logic wake_event_interrupt;
   logic device_ready;
   int err_total;
   int n_compared;
   // Wake line is pulled up when released
   wire wake_pin = wake_event_output_oe_n ? 1'b1 : wake_event_output;
   wes_link_if link ();
   wes_device #(.PULSE_CYCLES(PC), .STAB_CYCLES(SC)) i_wes_device (
      .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .link(link),
      .energy_src(energy_src), .frame_src(frame_src),
      .wake_event_output(wake_event_output), .wake_event_output_oe_n(wake_event_output_oe_n),
      .wake_event_interrupt(wake_event_interrupt), .device_ready(device_ready));
   wes_host i_wes_host (
      .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .link(link));
   wes_props #(.PULSE_CYCLES(PC), .STAB_CYCLES(SC)) i_wes_props (
      .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .req(link.req), .we(link.we),
      .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata),
      .wake_event_output(wake_event_output), .wake_event_output_oe_n(wake_event_output_oe_n),
      .wake_event_interrupt(wake_event_interrupt), .device_ready(device_ready));
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic test_done;
      if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic fail(input string m);
      err_total++;
      $display("MISMATCH %0t %s", $time, m);
      test_done();
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t %s got %h", $time, m, got);
      end
   endtask
   task automatic chk1(input logic got, input logic exp, input string m);
      chk32({31'h0, got}, {31'h0, exp}, m);
   endtask
   task automatic wait_rdy;
      int i;
      @(posedge hclk);
      for (i = 0; hreadyout !== 1'b1; i++) begin
         if (i > 20) fail("bus stall");
         @(posedge hclk);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      hsel <= 1'b1;
      wait_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask
   // One device access through the controller, waiting out busy
   task automatic dev(input logic w, input logic [7:0] off, input logic [31:0] d,
      output logic [31:0] r);
      logic [31:0] s;
      int i;
      if (w) ahb(1'b1, `WES_HOFF_WDATA, d, s);
      ahb(1'b1, `WES_HOFF_CMD, {16'h0, off, 7'h0, w}, s);
      repeat (3) @(posedge hclk);
      s = 32'h1;
      for (i = 0; s[`WES_ST_BUSY] !== 1'b0; i++) begin
         if (i > 20) fail("link stall");
         ahb(1'b0, `WES_HOFF_STATUS, 32'h0, s);
      end
      ahb(1'b0, `WES_HOFF_RDATA, 32'h0, r);
   endtask
   task automatic wait_ready;
      logic [31:0] r;
      int i;
      r = 32'h0;
      for (i = 0; r[0] !== 1'b1; i++) begin
         if (i > 50) fail("never ready");
         dev(1'b0, `WES_OFF_PWC, 32'h0, r);
      end
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_ready;
      logic [31:0] r;
      dev(1'b0, `WES_OFF_PWC, 32'h0, r);
      chk32(r & 32'h31, 32'h0, "early status");
      wait_ready();
      ahb(1'b0, `WES_HOFF_STATUS, 32'h0, r);
      chk1(r[`WES_ST_READY_SEEN], 1'b1, "ready seen");
      dev(1'b0, `WES_OFF_BYTE_TEST, 32'h0, r);
      chk32(r, `WES_BYTE_TEST_VAL, "byte test");
      dev(1'b0, 8'h90, 32'h0, r);
      chk32(r, 32'h0, "unmapped");
   endtask
   task automatic t_cause;
      logic [31:0] r;
      logic [31:0] c;
      for (int k = 1; k < 4; k++) begin
         c = 32'h342 | {29'h0, k[0], 2'h0};
         dev(1'b1, `WES_OFF_PWC, c, r);
         energy_src <= k[0];
         frame_src <= k[1];
         repeat (4) @(posedge hclk);
         dev(1'b1, `WES_OFF_PWC, c | 32'h30, r);
         energy_src <= 1'b0;
         frame_src <= 1'b0;
         dev(1'b0, `WES_OFF_PWC, 32'h0, r);
         chk32({30'h0, r[5:4]}, 32'(k), "cause held");
         chk1(wake_pin, k[0], "pin active");
         dev(1'b1, `WES_OFF_PWC, c | 32'h10, r);
         dev(1'b0, `WES_OFF_PWC, 32'h0, r);
         chk32({30'h0, r[5:4]}, 32'(k & 2), "one bit");
         dev(1'b1, `WES_OFF_PWC, c | 32'h20, r);
         chk1(wake_pin, ~k[0], "released");
      end
   endtask
   task automatic t_pulse;
      logic [31:0] r;
      int n;
      dev(1'b1, `WES_OFF_PWC, 32'h24e, r);
      frame_src <= 1'b1;
      for (n = 0; wake_pin !== 1'b1; n++) begin
         if (n > 20) fail("no pulse");
         @(negedge hclk);
      end
      for (n = 0; wake_pin === 1'b1 && n < 3 * PC; n++) @(negedge hclk);
      chk32(n, PC, "pulse width");
      repeat (2 * PC) @(negedge hclk);
      chk1(wake_pin, 1'b0, "retrigger");
      @(posedge hclk);
      frame_src <= 1'b0;
      dev(1'b1, `WES_OFF_PWC, 32'h27e, r);
   endtask
   task automatic t_oe;
      logic [31:0] r;
      dev(1'b1, `WES_OFF_PWC, 32'h204, r);
      frame_src <= 1'b1;
      repeat (4) @(posedge hclk);
      chk1(wake_event_interrupt, 1'b1, "irq");
      chk1(wake_pin, 1'b1, "pin gated");
      dev(1'b1, `WES_OFF_PWC, 32'h206, r);
      chk1(wake_pin, 1'b0, "open drain");
      frame_src <= 1'b0;
      dev(1'b1, `WES_OFF_PWC, 32'h006, r);
      chk1(wake_pin, 1'b1, "enable off");
      dev(1'b1, `WES_OFF_PWC, 32'h234, r);
   endtask
   task automatic t_sleep;
      logic [31:0] r;
      dev(1'b1, `WES_OFF_PWC, 32'h2200, r);
      repeat (4) @(posedge hclk);
      frame_src <= 1'b1;
      repeat (4) @(posedge hclk);
      frame_src <= 1'b0;
      repeat (4) @(posedge hclk);
      chk1(device_ready, 1'b0, "asleep");
      dev(1'b1, `WES_OFF_PWC, 32'h230, r);
      ahb(1'b0, `WES_HOFF_STATUS, 32'h0, r);
      chk1(r[`WES_ST_REFUSED], 1'b1, "refused");
      dev(1'b0, `WES_OFF_PWC, 32'h0, r);
      chk32(r & 32'h3031, 32'h2020, "sleep read");
      dev(1'b1, `WES_OFF_BYTE_TEST, 32'h0, r);
      wait_ready();
      dev(1'b0, `WES_OFF_PWC, 32'h0, r);
      chk32(r & 32'h3031, 32'h21, "woken");
      dev(1'b1, `WES_OFF_PWC, 32'h220, r);
      dev(1'b0, `WES_OFF_PWC, 32'h0, r);
      chk32(r & 32'h31, 32'h1, "cleared");
      ahb(1'b1, `WES_HOFF_STATUS, 32'h4, r);
      ahb(1'b0, `WES_HOFF_STATUS, 32'h0, r);
      chk1(r[`WES_ST_REFUSED], 1'b0, "refused cleared");
   endtask
   initial begin
      err_total = 0;
      n_compared = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      energy_src = 1'b0;
      frame_src = 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_ready();
      t_cause();
      t_pulse();
      t_oe();
      t_sleep();
      chk1(hresp, 1'b0, "response");
      test_done();
   end
endmodule
`default_nettype wire
